// ---- rtl/dwt_pkg.sv ----
// Purpose: constants for the two-channel watchdog / interval timer
// Assumes: AHB-Lite, 32-bit data, one register per aligned word
// Notes: printed offsets are not word aligned, so each is an index
package dwt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_WD0_CSR = 16'hffa8;
  localparam logic [15:0] IDX_WD0_CNT = 16'hffa9;
  localparam logic [15:0] IDX_SYSCTL = 16'hffc4;
  localparam logic [15:0] IDX_WD1_CSR = 16'hffea;
  localparam logic [15:0] IDX_WD1_CNT = 16'hffeb;
  // Password bytes in bits 15:8 of a write
  localparam logic [7:0] PW_CNT = 8'h5a;
  localparam logic [7:0] PW_CSR = 8'ha5;
  // Control/status field positions
  localparam int B_OVF = 7;
  localparam int B_MODE = 6;
  localparam int B_RUN = 5;
  localparam int B_PSEL = 4;
  localparam int B_ACT = 3;
  localparam int B_RSRC = 3;
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] SYSCTL_RST = 8'h09;
  // Writable bits of the system control register (bits 3 and 5 read-only)
  localparam logic [7:0] SYSCTL_WMASK = 8'hd7;
  // Internal reset hold time in system clock periods
  localparam int RST_HOLD_CYC = 518;
  localparam int PSM_W = 17;
  localparam int PSS_W = 8;
  // Tap bit index per divider code: divide by 2^(tap+1)
  localparam logic [4:0] PSM_TAP [8] = '{5'h00, 5'h05, 5'h06, 5'h08,
                                         5'h0a, 5'h0c, 5'h0e, 5'h10};
  localparam logic [4:0] PSS_TAP [8] = '{5'h00, 5'h01, 5'h02, 5'h03,
                                         5'h04, 5'h05, 5'h06, 5'h07};
  typedef enum logic [1:0] {
    DWT_HRD_RD = 2'b00,
    DWT_HRD_WR = 2'b01,
    DWT_HRD_NO = 2'b10
  } dwt_phase_t;
endpackage

// ---- rtl/dwt_top.sv ----
// Purpose: two-channel watchdog / interval timer with AHB-Lite registers
// Assumes: single clock hclk at 100 MHz, subclock pin sampled as data
// Notes: writes use the password word format on the csr address
//   Counter and control/status share a write index per channel;
//   the password byte picks which one is loaded
//   Counter reads use their own index; writes there are dropped
//   Requests are levels that follow the overflow flag
//   Software standby is not modelled here; state simply holds
//
// Functional notes
// - Two independent channels; overflow can raise reset or NMI.
// - Eight-bit up-counter advances on selected pulses only while running.
// - Wrap from all-ones sets overflow flag, then reset, NMI or interval.
// - Counter zero on reset, standby, and while run bit is 0.
// - Control/status clears on reset and hardware standby, kept in sleep.
// - Flag clears by read-as-one then write zero; writing one ignored.
// - Writing zero to run bit clears the overflow flag.
// - Watchdog reset overflow clears the flag through its own reset.
// - Mode bit: 0 interval interrupt, 1 watchdog reset or NMI.
// - Run bit 0 holds counter at zero, 1 lets it count.
// - Channel one bit 4 picks system or subclock prescaler.
// - Action bit in watchdog mode: 0 NMI, 1 internal reset.
// - System divider codes give 2,64,128,512,2048,8192,32768,131072.
// - Channel zero has eight clocks, channel one sixteen.
// - Subclock divider codes give 2 through 256 by powers of two.
// - Shared write address, word writes, 5A counter, A5 control/status.
// - Watchdog reset holds chip reset for 518 system clocks.
// - Reset source flag set by external reset, cleared by watchdog reset.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module dwt_top (
  input wire logic hclk, // System clock
  input wire logic hresetn, // External chip reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Ready once out of reset, low during reset
  output logic hresp, // Always OKAY
  input wire logic hw_standby, // Hardware standby request
  input wire logic subclock_input_pin, // External subclock
  output logic [1:0] interval_interrupt, // Interval request per channel
  output logic [1:0] nmi_req, // Watchdog NMI level per channel
  output logic internal_reset // Chip reset from watchdog overflow
);
  localparam int PSM_W_L = dwt_pkg::PSM_W;
  // Per-channel control/status, counter and clear-arming state
  logic [7:0] csr_r [2];
  logic [7:0] cnt_r [2];
  logic [1:0] armed_r;
  // Shared system control register
  logic [7:0] sysctl_r;
  // System-clock prescaler and its delayed copy for tap edges
  logic [PSM_W_L-1:0] psm_r;
  logic [PSM_W_L-1:0] psm_prev_r;
  // Subclock synchroniser, filtered level and its prescaler
  logic [2:0] sub_sync_r;
  logic sub_state_r;
  logic [dwt_pkg::PSS_W-1:0] pss_r;
  logic [dwt_pkg::PSS_W-1:0] pss_prev_r;
  // Remaining cycles of the internal reset pulse
  logic [9:0] hold_r;
  // Address phase capture, used in the following data phase
  logic dp_wr_r;
  logic dp_rd_r;
  logic [15:0] dp_idx_r;
  // Per-cycle events shared between the channel slices
  logic [1:0] wd_rst_req;
  logic [1:0] ovf_evt;
  logic [1:0] tick;
  logic clr_all;

  // Hardware standby and the watchdog reset both clear the timers
  // The watchdog reset clears its own flag, so it cannot retrigger
  // itself while the hold is running
  assign clr_all = hw_standby | internal_reset;

  // Bus address phase; only whole-word writes take effect, reads of any size
  // Byte and halfword writes are dropped here, so a stray narrow
  // store can never present a matching password
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_idx_r <= 16'h0000;
    end else if (hready) begin
      dp_wr_r <= hsel & htrans[1] & hwrite & (hsize == 3'h2);
      dp_rd_r <= hsel & htrans[1] & ~hwrite;
      dp_idx_r <= haddr[17:2];
    end else begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
    end
  end

  // Zero-wait slave, always OKAY
  // No wait states: every register answers from settled flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data registered at the address phase so it stands in data phase
  // Unmapped indices read zero; the only read side effect is the
  // flag-clear arming, kept in the channel slice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[17:2])
        dwt_pkg::IDX_WD0_CSR: hrdata <= {24'h000000, csr_r[0]};
        dwt_pkg::IDX_WD0_CNT: hrdata <= {24'h000000, cnt_r[0]};
        dwt_pkg::IDX_WD1_CSR: hrdata <= {24'h000000, csr_r[1]};
        dwt_pkg::IDX_WD1_CNT: hrdata <= {24'h000000, cnt_r[1]};
        dwt_pkg::IDX_SYSCTL: hrdata <= {24'h000000, sysctl_r};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Free-running prescalers; delayed copies give tap edges
  // Standby clears the divider so a restart begins in a known phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psm_r <= '0;
      psm_prev_r <= '0;
    end else if (hw_standby) begin
      psm_r <= '0;
      psm_prev_r <= '0;
    end else begin
      psm_r <= psm_r + 1'b1;
      psm_prev_r <= psm_r;
    end
  end

  // Subclock pin: three flops, edge counts when second and third agree
  // The pin runs on its own clock, so it is filtered before edge use
  // A level shorter than two system clocks is lost; subclock is slow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_sync_r <= 3'h0;
      sub_state_r <= 1'b0;
      pss_r <= '0;
      pss_prev_r <= '0;
    end else begin
      sub_sync_r <= {sub_sync_r[1:0], subclock_input_pin};
      pss_prev_r <= pss_r;
      if (sub_sync_r[1] == sub_sync_r[2]) begin
        sub_state_r <= sub_sync_r[2];
        if (sub_sync_r[2] && !sub_state_r) begin
          pss_r <= pss_r + 1'b1;
        end
      end
      // Standby clears the subclock divider too; last assignment wins
      if (hw_standby) begin
        pss_r <= '0;
        pss_prev_r <= '0;
      end
    end
  end

  // Count pulse per channel: falling edge of the selected tap
  // A falling tap edge lasts one cycle, so each pulse counts once
  // Channel zero always uses the system-clock divider
  always_comb begin
    tick[0] = psm_prev_r[dwt_pkg::PSM_TAP[csr_r[0][2:0]]] &
              ~psm_r[dwt_pkg::PSM_TAP[csr_r[0][2:0]]];
    if (csr_r[1][dwt_pkg::B_PSEL]) begin
      tick[1] = pss_prev_r[dwt_pkg::PSS_TAP[csr_r[1][2:0]][2:0]] &
                ~pss_r[dwt_pkg::PSS_TAP[csr_r[1][2:0]][2:0]];
    end else begin
      tick[1] = psm_prev_r[dwt_pkg::PSM_TAP[csr_r[1][2:0]]] &
                ~psm_r[dwt_pkg::PSM_TAP[csr_r[1][2:0]]];
    end
  end

  // Per-channel counter, flag and requests
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      // Decoded accesses for this channel's slice
      logic wr_hit;
      logic cnt_wr;
      logic csr_wr;
      logic rd_csr;
      assign wr_hit = dp_wr_r && dp_idx_r ==
        (ch == 0 ? dwt_pkg::IDX_WD0_CSR : dwt_pkg::IDX_WD1_CSR);
      assign cnt_wr = wr_hit && hwdata[15:8] == dwt_pkg::PW_CNT;
      assign csr_wr = wr_hit && hwdata[15:8] == dwt_pkg::PW_CSR;
      assign rd_csr = dp_rd_r && dp_idx_r ==
        (ch == 0 ? dwt_pkg::IDX_WD0_CSR : dwt_pkg::IDX_WD1_CSR);
      // Overflow is the wrap from all-ones on a count pulse
      assign ovf_evt[ch] = csr_r[ch][dwt_pkg::B_RUN] && tick[ch] &&
                           cnt_r[ch] == dwt_pkg::CNT_MAX;
      assign wd_rst_req[ch] = ovf_evt[ch] && csr_r[ch][dwt_pkg::B_MODE] &&
                              csr_r[ch][dwt_pkg::B_ACT];

      // Counter: held at zero unless running
      // Clear and halt beat a password write, which beats a count pulse,
      // so a refresh in the overflow cycle still restarts the count
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_r[ch] <= dwt_pkg::CNT_RST;
        end else if (clr_all || !csr_r[ch][dwt_pkg::B_RUN]) begin
          cnt_r[ch] <= dwt_pkg::CNT_RST;
        end else if (cnt_wr) begin
          cnt_r[ch] <= hwdata[7:0];
        end else if (tick[ch]) begin
          cnt_r[ch] <= cnt_r[ch] + 8'h01;
        end
      end

      // Read-as-one arms the flag clear; any later csr write disarms
      // Disarming on every write stops a stale read from clearing a
      // flag that was set again after it
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          armed_r[ch] <= 1'b0;
        end else if (clr_all || csr_wr) begin
          armed_r[ch] <= 1'b0;
        end else if (rd_csr && csr_r[ch][dwt_pkg::B_OVF]) begin
          armed_r[ch] <= 1'b1;
        end
      end

      // Control bits and overflow flag; a new overflow beats a clear
      // The flag bit is never loaded from the bus; only clears reach it,
      // so a written one is ignored
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          csr_r[ch] <= dwt_pkg::CSR_RST;
        end else if (clr_all) begin
          csr_r[ch] <= dwt_pkg::CSR_RST;
        end else begin
          if (csr_wr) begin
            csr_r[ch][6:0] <= hwdata[6:0];
          end
          if (ovf_evt[ch]) begin
            csr_r[ch][dwt_pkg::B_OVF] <= 1'b1;
          end else if (csr_wr && !hwdata[dwt_pkg::B_RUN]) begin
            csr_r[ch][dwt_pkg::B_OVF] <= 1'b0;
          end else if (csr_wr && armed_r[ch] &&
                       !hwdata[dwt_pkg::B_OVF]) begin
            csr_r[ch][dwt_pkg::B_OVF] <= 1'b0;
          end
        end
      end

      // Requests follow the flag so software clearing it drops them
      // They trail the flag by one cycle; software sees the flag first
      // and a request stands one cycle on after its flag clears
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          interval_interrupt[ch] <= 1'b0;
          nmi_req[ch] <= 1'b0;
        end else begin
          interval_interrupt[ch] <= csr_r[ch][dwt_pkg::B_OVF] &
                                    ~csr_r[ch][dwt_pkg::B_MODE];
          nmi_req[ch] <= csr_r[ch][dwt_pkg::B_OVF] &
                         csr_r[ch][dwt_pkg::B_MODE] &
                         ~csr_r[ch][dwt_pkg::B_ACT];
        end
      end
    end
  endgenerate

  // Internal reset: counted hold after a watchdog reset overflow
  // A new request is taken only once the previous pulse has ended,
  // so the pulse length never stretches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_r <= 10'h000;
      internal_reset <= 1'b0;
    end else if (|wd_rst_req && !internal_reset) begin
      hold_r <= 10'(dwt_pkg::RST_HOLD_CYC - 1);
      internal_reset <= 1'b1;
    end else if (hold_r != 10'h000) begin
      hold_r <= hold_r - 10'h001;
    end else begin
      internal_reset <= 1'b0;
    end
  end

  // System control: reset-source bit and bit 5 read-only, other bits plain storage
  // The reset-source bit tells software whether the last reset came
  // from the pin or from a watchdog overflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysctl_r <= dwt_pkg::SYSCTL_RST;
    end else if (|wd_rst_req && !internal_reset) begin
      sysctl_r <= dwt_pkg::SYSCTL_RST & ~(8'h01 << dwt_pkg::B_RSRC);
    end else if (dp_wr_r && dp_idx_r == dwt_pkg::IDX_SYSCTL) begin
      sysctl_r <= (hwdata[7:0] & dwt_pkg::SYSCTL_WMASK) |
                  (sysctl_r & ~dwt_pkg::SYSCTL_WMASK);
    end
  end
endmodule

// ---- sim/dwt_assertions.sv ----
// Purpose: port checks for the two-channel watchdog timer
// Assumes: one clock, hresetn async active low
// Notes: a counter measures the internal reset length
`timescale 1ns/1ns
module dwt_checker (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Slave select
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write strobe
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic hw_standby, // Standby request
  input wire logic [1:0] interval_interrupt, // Interval levels
  input wire logic [1:0] nmi_req, // NMI levels
  input wire logic internal_reset // Watchdog reset
);
  logic [9:0] hold_r;
  logic rd_take;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase accepted
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  // Hold length is far past any repetition count, so count it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hold_r <= 10'h000;
    else if (internal_reset)
      hold_r <= hold_r + 10'h001;
    else
      hold_r <= 10'h000;
  end
  sequence s_stby;
    hw_standby [*3];
  endsequence
  sequence s_wiped;
    ##[1:4] (nmi_req == 2'h0 && interval_interrupt == 2'h0);
  endsequence
  a_ready_high: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low outside reset");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_mode_excl0: assert property (!(nmi_req[0] && interval_interrupt[0]))
    else $error("channel 0 nmi and interval together");
  a_mode_excl1: assert property (!(nmi_req[1] && interval_interrupt[1]))
    else $error("channel 1 nmi and interval together");
  a_hold_len: assert property ($fell(internal_reset) |-> hold_r == 10'h206)
    else $error("internal reset length wrong");
  a_hold_bound: assert property (internal_reset |-> hold_r < 10'h206)
    else $error("internal reset too long");
  a_flag_wipe: assert property ($rose(internal_reset) |-> s_wiped)
    else $error("flags not cleared by internal reset");
  a_rd_stable: assert property (!rd_take |=> $stable(hrdata))
    else $error("hrdata changed without a read");
  a_stby_clear: assert property (s_stby |-> nmi_req == 2'h0 &&
    interval_interrupt == 2'h0)
    else $error("requests not cleared in standby");
endmodule
bind dwt_top dwt_checker dwt_checker_inst (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .hw_standby,
  .interval_interrupt, .nmi_req, .internal_reset);

// ---- sim/tb.sv ----
// Purpose: directed bench for the two-channel watchdog timer
// Assumes: zero-wait AHB-Lite slave, byte address four times the index
// Notes: rates are counts over a fixed window, one count of phase slack
`timescale 1ns/1ns
module tb;
  localparam logic [15:0] cs0 = dwt_pkg::IDX_WD0_CSR;
  localparam logic [15:0] cs1 = dwt_pkg::IDX_WD1_CSR;
  localparam logic [15:0] sc = dwt_pkg::IDX_SYSCTL;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hw_standby = 1'b0;
  logic subclock_input_pin = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [1:0] interval_interrupt, nmi_req;
  logic hreadyout, hresp, internal_reset;
  logic [7:0] a;
  int num_errors = 0;
  int compares = 0;
  int dv [5] = '{2, 64, 128, 512, 2048};
  always #5 hclk = ~hclk;
  // Slow subclock, six system clocks a period
  always begin
    repeat (3) @(posedge hclk);
    subclock_input_pin <= ~subclock_input_pin;
  end
  dwt_top dwt_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .hw_standby, .subclock_input_pin, .interval_interrupt, .nmi_req,
    .internal_reset);
  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single transfer; called right after a rising edge
  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [31:0] d, input logic [2:0] sz);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {14'h0, i, 2'h0};
    hwrite <= w;
    hsize <= sz;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    bus(1'b1, i, {16'h0, d}, 3'h2);
  endtask
  task automatic rdc(input logic [15:0] i, input logic [7:0] e);
    bus(1'b0, i, 32'h0, 3'h2);
    chk(rd, {24'h0, e});
  endtask
  // Bits: 4 internal reset, 3:2 nmi, 1:0 interval
  task automatic wait_sig(input int k, input int lim);
    logic [4:0] v;
    for (int n = 0; n < lim; n++) begin
      @(posedge hclk);
      v = {internal_reset, nmi_req, interval_interrupt};
      if (v[k] === 1'b1)
        return;
    end
    num_errors++;
    test_done();
  endtask
  // Eight pulses expected across a window of 8*p clocks
  task automatic rate(input logic [15:0] i, input logic [7:0] c, input int p);
    wr(i, 16'ha500);
    wr(i, {8'ha5, c});
    bus(1'b0, i + 16'h1, 32'h0, 3'h2);
    a = rd[7:0];
    repeat (8 * p - 2) @(posedge hclk);
    bus(1'b0, i + 16'h1, 32'h0, 3'h2);
    a = rd[7:0] - a;
    chk({31'h0, (a inside {[8'h07:8'h09]})}, 32'h1);
    wr(i, 16'ha500);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc(cs0, 8'h00);
    rdc(cs0 + 16'h1, 8'h00);
    rdc(sc, 8'h09);
    rdc(cs1, 8'h00);
    rdc(16'h0100, 8'h00);
    // Refused writes: flag one, no password, byte size, counter halted
    wr(cs0, 16'ha580);
    wr(cs0, 16'h0020);
    bus(1'b1, cs0, 32'h0000a520, 3'h0);
    rdc(cs0, 8'h00);
    // System control keeps its two read-only bits whatever is written
    wr(sc, 16'h00ff);
    rdc(sc, 8'hdf);
    wr(sc, 16'h0001);
    rdc(sc, 8'h09);
    wr(cs0, 16'h5a44);
    rdc(cs0 + 16'h1, 8'h00);
    // Interval overflow on channel 0
    wr(cs0, 16'ha520);
    wr(cs0, 16'h5afd);
    wait_sig(0, 50);
    chk({30'h0, nmi_req}, 32'h0);
    wr(cs0, 16'ha520);
    rdc(cs0, 8'ha0);
    wr(cs0, 16'ha520);
    rdc(cs0, 8'h20);
    wr(cs0, 16'ha500);
    chk({31'h0, interval_interrupt[0]}, 32'h0);
    // Watchdog NMI on channel 1, then stop clears the flag
    wr(cs1, 16'ha560);
    wr(cs1, 16'h5afd);
    wait_sig(3, 50);
    chk({31'h0, interval_interrupt[1]}, 32'h0);
    wr(cs1, 16'ha540);
    rdc(cs1, 8'h40);
    rdc(cs1 + 16'h1, 8'h00);
    chk({31'h0, nmi_req[1]}, 32'h0);
    // Standby while an NMI request stands
    wr(cs1, 16'ha560);
    wr(cs1, 16'h5afd);
    wait_sig(3, 50);
    hw_standby <= 1'b1;
    repeat (3) @(posedge hclk);
    hw_standby <= 1'b0;
    @(posedge hclk);
    chk({30'h0, nmi_req}, 32'h0);
    rdc(cs1, 8'h00);
    rdc(cs1 + 16'h1, 8'h00);
    for (int k = 0; k < 5; k++)
      rate(cs0, 8'h20 | 8'(k), dv[k]);
    for (int k = 0; k < 3; k++)
      rate(cs1, 8'h30 | 8'(k), 12 << k);
    rate(cs1, 8'h21, 64);
    // Channel 1 interval flag up, then watchdog reset on channel 0
    wr(cs1, 16'ha520);
    wr(cs1, 16'h5afd);
    wait_sig(1, 50);
    wr(cs0, 16'ha568);
    wr(cs0, 16'h5afd);
    wait_sig(4, 50);
    repeat (600) @(posedge hclk);
    chk({31'h0, internal_reset}, 32'h0);
    rdc(cs0, 8'h00);
    rdc(cs1, 8'h00);
    chk({30'h0, interval_interrupt}, 32'h0);
    rdc(sc, 8'h01);
    test_done();
  end
endmodule
